/* File: hdl/tas_pkg.sv */
// shared constants and types of the thermal alarm slave
package tas_pkg;
  // fixed upper nibble of the 7-bit bus address
  localparam logic [3:0] ADDR_PREFIX = 4'h9;
  // pointer codes selecting a register
  localparam logic [1:0] PTR_TEMP = 2'h0;
  localparam logic [1:0] PTR_CFG = 2'h1;
  localparam logic [1:0] PTR_HYST = 2'h2;
  localparam logic [1:0] PTR_SET = 2'h3;
  // configuration field positions
  localparam int CFG_SHDN = 0;
  localparam int CFG_MODE = 1;
  localparam int CFG_POL = 2;
  localparam int CFG_FQ_LO = 3;
  localparam int CFG_W = 5;
  // reset values: comparator, active-low, queue of one, 80 and 75 degrees
  localparam logic [4:0] CFG_RESET = 5'h00;
  localparam logic [15:0] SET_RESET = 16'h5000;
  localparam logic [15:0] HYST_RESET = 16'h4b00;
  localparam logic [1:0] PTR_RESET = 2'h0;
  // temperature code: 9-bit two's complement, half-degree steps, left aligned
  localparam int TEMP_W = 9;
  // consecutive matching conversions per queue code
  localparam logic [2:0] FQ_N0 = 3'h1;
  localparam logic [2:0] FQ_N1 = 3'h2;
  localparam logic [2:0] FQ_N2 = 3'h4;
  localparam logic [2:0] FQ_N3 = 3'h6;
  // byte slot of a write transfer
  localparam logic [1:0] IDX_PTR = 2'h0;
  localparam logic [1:0] IDX_HI = 2'h1;
  localparam logic [1:0] IDX_LO = 2'h2;
  // conversion period
  localparam int CLK_MHZ = 100;
  localparam int CONV_TIME_MS = 100;
  localparam int CONV_CYCLES = CONV_TIME_MS * 1000 * CLK_MHZ;
  // link engine states
  typedef enum logic [2:0] {
    LS_IDLE, LS_ADDR, LS_AACK, LS_WR, LS_WACK, LS_RD, LS_RACK
  } tas_link_state_type;
  // qualitative outcome of one conversion
  typedef enum logic [1:0] {OC_NONE, OC_HOT, OC_COLD} tas_outcome_type;
endpackage

/* File: hdl/tas_link_if.sv */
// carrier between the link engine and the alarm core
`timescale 1ns/1ps
interface tas_link_if;
  logic wr_tog;
  logic [1:0] wr_idx;
  logic [7:0] wr_byte;
  logic rd_tog;
  logic rd_ack_tog;
  logic [15:0] rd_word;
  modport eng (output wr_tog, output wr_idx, output wr_byte, output rd_tog,
               input rd_ack_tog, input rd_word);
  modport core (input wr_tog, input wr_idx, input wr_byte, input rd_tog,
                output rd_ack_tog, output rd_word);
endinterface

/* File: hdl/tas_link_engine.sv */
// two-wire bus slave engine on the link clock
`timescale 1ns/1ps
module tas_link_engine (
  input wire logic link_clk_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [2:0] addr_sel_i,
  output logic sda_oe_o,
  tas_link_if.eng lnk
);
  logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  logic [2:0] as_m_q, as_s_q;
  logic ack_m_q, ack_s_q, ack_p_q;
  tas_pkg::tas_link_state_type st_q;
  logic [2:0] cnt_q;
  logic [7:0] sh_q;
  logic [15:0] tx_q, word_q;
  logic full_q, rw_q, ackok_q, wr_tog_q, rd_tog_q;
  logic [1:0] idx_q, wr_idx_q;
  logic [7:0] wr_byte_q;
  // bus conditions seen on synchronised lines
  wire rise = scl_s_q & ~scl_p_q;
  wire fall = ~scl_s_q & scl_p_q;
  wire start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire stop = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  wire match = (sh_q[7:4] == tas_pkg::ADDR_PREFIX) && (sh_q[3:1] == as_s_q);
  assign lnk.wr_tog = wr_tog_q;
  assign lnk.wr_idx = wr_idx_q;
  assign lnk.wr_byte = wr_byte_q;
  assign lnk.rd_tog = rd_tog_q;
  // pin synchronisers and answer toggle crossing
  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q} <= 6'h3f;
      {as_m_q, as_s_q} <= 6'h00;
      {ack_m_q, ack_s_q, ack_p_q} <= 3'h0;
      word_q <= 16'h0000;
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {scl_i, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {sda_i, sda_m_q, sda_s_q};
      {as_m_q, as_s_q} <= {addr_sel_i, as_m_q};
      {ack_m_q, ack_s_q, ack_p_q} <= {lnk.rd_ack_tog, ack_m_q, ack_s_q};
      if (ack_s_q != ack_p_q) begin
        word_q <= lnk.rd_word; // word stays still after its toggle
      end
    end
  end
  // byte framing, acknowledge and shift-out
  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= tas_pkg::LS_IDLE;
      {cnt_q, sh_q, tx_q, full_q, rw_q, ackok_q} <= 30'h0;
      {wr_tog_q, rd_tog_q, idx_q, wr_idx_q, wr_byte_q, sda_oe_o} <= 15'h0;
    end else if (start) begin
      st_q <= tas_pkg::LS_ADDR;
      {cnt_q, full_q, idx_q, sda_oe_o} <= 7'h00;
    end else if (stop) begin
      st_q <= tas_pkg::LS_IDLE;
      sda_oe_o <= 1'b0;
    end else if (rise && (st_q == tas_pkg::LS_ADDR || st_q == tas_pkg::LS_WR)) begin
      sh_q <= {sh_q[6:0], sda_s_q};
      cnt_q <= cnt_q + 3'h1;
      full_q <= (cnt_q == 3'h7);
    end else if (rise && st_q == tas_pkg::LS_RACK) begin
      ackok_q <= ~sda_s_q; // master ack asks for another byte
    end else if (fall) begin
      case (st_q)
        tas_pkg::LS_ADDR: if (full_q) begin
          full_q <= 1'b0;
          rw_q <= sh_q[0];
          sda_oe_o <= match;
          st_q <= match ? tas_pkg::LS_AACK : tas_pkg::LS_IDLE;
          rd_tog_q <= rd_tog_q ^ (match & sh_q[0]);
        end
        tas_pkg::LS_WR: if (full_q) begin
          {full_q, sda_oe_o} <= 2'b01;
          st_q <= tas_pkg::LS_WACK;
          {wr_byte_q, wr_idx_q} <= {sh_q, idx_q};
          wr_tog_q <= ~wr_tog_q;
          idx_q <= (idx_q == tas_pkg::IDX_LO) ? idx_q : idx_q + 2'h1;
        end
        tas_pkg::LS_AACK: begin
          st_q <= rw_q ? tas_pkg::LS_RD : tas_pkg::LS_WR;
          tx_q <= word_q;
          sda_oe_o <= rw_q & ~word_q[15];
          cnt_q <= 3'h0;
        end
        tas_pkg::LS_WACK: begin
          sda_oe_o <= 1'b0;
          st_q <= tas_pkg::LS_WR;
        end
        tas_pkg::LS_RD: begin
          cnt_q <= cnt_q + 3'h1;
          tx_q <= {tx_q[14:0], 1'b0};
          sda_oe_o <= (cnt_q != 3'h7) & ~tx_q[14];
          st_q <= (cnt_q == 3'h7) ? tas_pkg::LS_RACK : tas_pkg::LS_RD;
        end
        tas_pkg::LS_RACK: begin
          st_q <= ackok_q ? tas_pkg::LS_RD : tas_pkg::LS_IDLE;
          // low byte msb already stands at the top after eight shifts
          sda_oe_o <= ackok_q & ~tx_q[15];
          cnt_q <= 3'h0;
        end
        default: st_q <= st_q;
      endcase
    end
  end
endmodule

/* File: hdl/tas_core.sv */
// thermal alarm core: registers, conversion timing, fault queue and alert pin
`timescale 1ns/1ps
// Notes on behaviour
// - comparator mode: above setpoint raises alert
// - comparator alert clears below hysteresis limit
// - interrupt alert latches until any register read
// - after read, drop below hysteresis re-alerts
// - register read also clears hysteresis alert
// - interrupt mode: entering shutdown clears alert
// - comparator mode: alert held during shutdown
// - polarity bit selects level, default active-low
// - address upper nibble must be 1001
// - low address bits match select pins
// - shutdown bit halts all conversions
// - bus keeps working during shutdown
// - alert sets, and comparator alert clears, only after N matching conversions
// - queue code selects 1, 2, 4 or 6
// - config bits: shutdown, mode, polarity, two queue bits
module tas_core #(
  parameter int CONV_CYCLES = tas_pkg::CONV_CYCLES // cycles between conversions
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic link_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic addr_select_high_i,
  input wire logic addr_select_mid_i,
  input wire logic addr_select_low_i,
  input wire logic [8:0] temp_code_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic alert_output_o,
  output logic shutdown_o,
  output logic conv_start_o
);

  // carrier between the two clock domains
  tas_link_if lnk ();

  // decoding used for the fault queue depth
  function automatic logic [2:0] fq_need(input logic [1:0] code);
    logic [2:0] n;
    n = tas_pkg::FQ_N0;
    if (code == 2'h1) begin
      n = tas_pkg::FQ_N1;
    end else if (code == 2'h2) begin
      n = tas_pkg::FQ_N2;
    end else if (code == 2'h3) begin
      n = tas_pkg::FQ_N3;
    end
    return n;
  endfunction

  // register file
  logic [1:0] ptr_q; // register pointer
  logic [tas_pkg::CFG_W-1:0] cfg_q; // configuration bits
  logic [15:0] set_q; // trip setpoint
  logic [15:0] hyst_q; // hysteresis limit
  logic [7:0] hi_q; // first data byte of a word write
  logic [tas_pkg::TEMP_W-1:0] temp_q; // last converted temperature

  // crossing stages from the link domain
  logic wr_m_q, wr_s_q, wr_p_q;
  logic rd_m_q, rd_s_q, rd_p_q;
  logic rd_ack_q; // answer toggle back to the link
  logic [15:0] rd_word_q; // word held for the link

  // temperature code synchroniser
  logic [tas_pkg::TEMP_W-1:0] tc_m_q, tc_s_q;

  // conversion timebase
  logic [31:0] tb_q;
  logic conv_q; // one-cycle pulse, a conversion result is taken

  // fault queue
  tas_pkg::tas_outcome_type last_q; // outcome of previous conversion
  logic [2:0] fq_cnt_q; // consecutive matching conversions
  logic hot_qual_q; // qualified above-setpoint result pending
  logic cold_qual_q; // qualified below-hysteresis result pending

  // alert state
  logic alert_q; // alert active, polarity not yet applied
  logic arm_hot_q; // interrupt mode waits for a setpoint event
  logic shdn_p_q; // shutdown bit one cycle ago
  logic alert_p_q; // alert state one cycle ago
  logic moved_q; // alert moved since the last conversion

  // named decode wires
  wire wr_ev = wr_s_q ^ wr_p_q; // byte arrived from the link
  wire rd_ev = rd_s_q ^ rd_p_q; // read transfer started
  wire shdn = cfg_q[tas_pkg::CFG_SHDN];
  wire int_mode = cfg_q[tas_pkg::CFG_MODE];
  wire pol_high = cfg_q[tas_pkg::CFG_POL];
  wire [1:0] fq_code = cfg_q[tas_pkg::CFG_FQ_LO +: 2];
  wire [2:0] need = fq_need(fq_code);
  wire shdn_enter = shdn & ~shdn_p_q;
  wire tick = (tb_q == 32'(CONV_CYCLES - 1));
  wire signed [tas_pkg::TEMP_W-1:0] t_s = $signed(tc_s_q);
  wire signed [tas_pkg::TEMP_W-1:0] set_s = $signed(set_q[15 -: tas_pkg::TEMP_W]);
  wire signed [tas_pkg::TEMP_W-1:0] hyst_s = $signed(hyst_q[15 -: tas_pkg::TEMP_W]);
  wire is_hot = t_s > set_s;
  wire is_cold = t_s < hyst_s;
  wire tas_pkg::tas_outcome_type outcome = is_hot ? tas_pkg::OC_HOT :
                                           is_cold ? tas_pkg::OC_COLD : tas_pkg::OC_NONE;
  wire alert_chg = moved_q; // an alert move restarts the queue
  wire restart = (outcome != last_q) | alert_chg;
  wire [2:0] cnt_next = restart ? 3'h1 : ((fq_cnt_q == tas_pkg::FQ_N3) ? fq_cnt_q : fq_cnt_q + 3'h1);

  // interrupt-mode and comparator-mode events
  wire int_set_hot = int_mode & arm_hot_q & hot_qual_q & ~alert_q;
  wire int_set_cold = int_mode & ~arm_hot_q & cold_qual_q & ~alert_q;
  wire int_set = int_set_hot | int_set_cold;
  wire cmp_set = ~int_mode & hot_qual_q;
  wire cmp_clr = ~int_mode & cold_qual_q;

  // word shown to the link for the current pointer
  wire [15:0] sel_word = (ptr_q == tas_pkg::PTR_TEMP) ? {temp_q, 7'h00} :
                         (ptr_q == tas_pkg::PTR_CFG) ? {3'h0, cfg_q, 3'h0, cfg_q} :
                         (ptr_q == tas_pkg::PTR_HYST) ? hyst_q : set_q;

  assign lnk.rd_ack_tog = rd_ack_q;
  assign lnk.rd_word = rd_word_q;

  // bus slave engine on the link clock
  tas_link_engine u_eng (
    .link_clk_i (link_clk_i),
    .reset_n_i (reset_n_i),
    .scl_i (scl_i),
    .sda_i (sda_i),
    .addr_sel_i ({addr_select_high_i, addr_select_mid_i, addr_select_low_i}),
    .sda_oe_o (sda_oe_o),
    .lnk (lnk.eng)
  );

  // toggle synchronisers for link events and the temperature code
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {wr_m_q, wr_s_q, wr_p_q} <= 3'h0;
      {rd_m_q, rd_s_q, rd_p_q} <= 3'h0;
      tc_m_q <= '0;
      tc_s_q <= '0;
    end else begin
      {wr_m_q, wr_s_q, wr_p_q} <= {lnk.wr_tog, wr_m_q, wr_s_q};
      {rd_m_q, rd_s_q, rd_p_q} <= {lnk.rd_tog, rd_m_q, rd_s_q};
      tc_m_q <= temp_code_i;
      tc_s_q <= tc_m_q;
    end
  end

  // register writes; the bus stays live during shutdown
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ptr_q <= tas_pkg::PTR_RESET;
      cfg_q <= tas_pkg::CFG_RESET;
      set_q <= tas_pkg::SET_RESET;
      hyst_q <= tas_pkg::HYST_RESET;
      hi_q <= 8'h00;
    end else if (wr_ev) begin
      if (lnk.wr_idx == tas_pkg::IDX_PTR) begin
        ptr_q <= lnk.wr_byte[1:0];
      end else if (lnk.wr_idx == tas_pkg::IDX_HI && ptr_q == tas_pkg::PTR_CFG) begin
        cfg_q <= lnk.wr_byte[tas_pkg::CFG_W-1:0];
      end else if (lnk.wr_idx == tas_pkg::IDX_HI) begin
        hi_q <= lnk.wr_byte;
      end else if (ptr_q == tas_pkg::PTR_HYST) begin
        hyst_q <= {hi_q, lnk.wr_byte[7], 7'h00};
      end else if (ptr_q == tas_pkg::PTR_SET) begin
        set_q <= {hi_q, lnk.wr_byte[7], 7'h00};
      end
    end
  end

  // read answer: snapshot the word, toggle back to the link
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_ack_q <= 1'b0;
      rd_word_q <= 16'h0000;
    end else if (rd_ev) begin
      rd_word_q <= sel_word;
      rd_ack_q <= ~rd_ack_q;
    end
  end

  // conversion timebase, halted in shutdown
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tb_q <= 32'h0000_0000;
      conv_q <= 1'b0;
      conv_start_o <= 1'b0;
    end else begin
      tb_q <= (tick | shdn) ? 32'h0000_0000 : tb_q + 32'h1;
      conv_q <= tick & ~shdn;
      conv_start_o <= tick & ~shdn;
    end
  end

  // latest temperature and the fault queue
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      temp_q <= '0;
      last_q <= tas_pkg::OC_NONE;
      fq_cnt_q <= 3'h0;
      hot_qual_q <= 1'b0;
      cold_qual_q <= 1'b0;
    end else if (conv_q) begin
      temp_q <= tc_s_q;
      last_q <= outcome;
      fq_cnt_q <= cnt_next;
      hot_qual_q <= (outcome == tas_pkg::OC_HOT) && (cnt_next >= need);
      cold_qual_q <= (outcome == tas_pkg::OC_COLD) && (cnt_next >= need);
    end else begin
      hot_qual_q <= 1'b0;
      cold_qual_q <= 1'b0;
    end
  end

  // alert state in both modes
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      alert_q <= 1'b0;
      arm_hot_q <= 1'b1;
      shdn_p_q <= 1'b0;
    end else begin
      shdn_p_q <= shdn;
      if (int_mode && shdn_enter) begin
        alert_q <= 1'b0;
      end else if (cmp_set) begin
        alert_q <= 1'b1;
      end else if (cmp_clr) begin
        alert_q <= 1'b0;
      end else if (int_set) begin
        alert_q <= 1'b1; // set wins over a read in the same cycle
        arm_hot_q <= int_set_cold;
      end else if (int_mode && rd_ev) begin
        alert_q <= 1'b0;
      end
      // comparator state simply holds while shutdown stops conversions
    end
  end

  // alert movement seen by the next conversion; a move wins over the clear
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      alert_p_q <= 1'b0;
      moved_q <= 1'b0;
    end else begin
      alert_p_q <= alert_q;
      moved_q <= (alert_q != alert_p_q) | (moved_q & ~conv_q);
    end
  end

  // pin levels: polarity applied at the output flip-flop
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      alert_output_o <= 1'b1;
      shutdown_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      alert_output_o <= pol_high ? alert_q : ~alert_q;
      shutdown_o <= shdn;
      sda_o <= 1'b0; // open drain: only the enable moves
    end
  end

endmodule

/* File: sim/tas_host_model.sv */
// two-wire bus master model for the thermal alarm core
`timescale 1ns/1ps
module tas_host_model (
  input wire logic sda_i,
  output logic scl_o,
  output logic pull_o
);
  // idle bus: clock high, data released to the pull-up
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end
  // one bit slot: data set while clock low, sampled mid high
  task automatic bit_io(input logic b, output logic r);
    pull_o = !b;
    #200 scl_o = 1'b1;
    #100 r = sda_i;
    #100 scl_o = 1'b0;
    #100;
  endtask
  // start: data falls while clock high
  task automatic bus_start();
    pull_o = 1'b0;
    #100 scl_o = 1'b1;
    #200 pull_o = 1'b1;
    #200 scl_o = 1'b0;
    #100;
  endtask
  // stop: data rises while clock high, clock then stands high
  task automatic bus_stop();
    pull_o = 1'b1;
    #100 scl_o = 1'b1;
    #200 pull_o = 1'b0;
    #200;
  endtask
  // eight bits msb first, then the acknowledge slot
  task automatic frame(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) bit_io(d[i], q[i]);
  endtask
  // address byte: fixed prefix, pin bits, direction bit
  task automatic address(input logic [2:0] pins, input logic rd, output logic ack);
    logic [8:0] q;
    frame({tas_pkg::ADDR_PREFIX, pins, rd, 1'b1}, q);
    ack = !q[0];
  endtask
endmodule

/* File: sim/tas_core_chk.sv */
// port checker for the thermal alarm core
`timescale 1ns/1ps
module tas_core_chk #(
  parameter int CONV_CYCLES = tas_pkg::CONV_CYCLES // conversion spacing
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic link_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic alert_output_o,
  input wire logic shutdown_o,
  input wire logic conv_start_o
);
  logic [4:0] idle_q; // quiet bus cycles, saturating
  logic [31:0] gap_q; // cycles since last conversion, saturating
  wire idle = idle_q == 5'h1f;
  // bus quiet time and conversion spacing
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idle_q <= 5'h00;
      gap_q <= 32'hffff_ffff;
    end else begin
      idle_q <= !(scl_i && sda_i) ? 5'h00 : (idle ? idle_q : idle_q + 5'h01);
      gap_q <= conv_start_o ? 32'h0000_0000 : (&gap_q ? gap_q : gap_q + 32'h0000_0001);
    end
  end
  a_conv_gap: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    conv_start_o |-> gap_q >= 32'(CONV_CYCLES - 1)) else $error("conversion too early");
  a_shdn_noconv: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    shutdown_o && $past(shutdown_o) |-> !conv_start_o) else $error("conversion in shutdown");
  a_alert_conv: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    idle && $changed(alert_output_o) |-> $past(conv_start_o, 3) || $past(conv_start_o, 4))
    else $error("alert moved without conversion");
  a_alert_shdn: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    idle && shutdown_o && $past(shutdown_o) |-> $stable(alert_output_o)) else $error("alert moved in shutdown");
  a_shdn_bus: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    idle |-> $stable(shutdown_o)) else $error("shutdown moved without bus write");
  a_oe_idle: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    idle |-> !sda_oe_o) else $error("data pulled on idle bus");
  a_oe_scl_low: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    $changed(sda_oe_o) |-> !scl_i) else $error("data drive moved with clock high");
  a_sda_low: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    sda_o == 1'b0) else $error("open drain value not zero");
  c_conv: cover property (@(posedge clock_i) disable iff (!reset_n_i) conv_start_o);
  c_ack: cover property (@(posedge link_clk_i) disable iff (!reset_n_i) $rose(sda_oe_o));
  c_alert: cover property (@(posedge clock_i) disable iff (!reset_n_i) $fell(alert_output_o));
endmodule
bind tas_core tas_core_chk #(.CONV_CYCLES(CONV_CYCLES)) chk (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .link_clk_i(link_clk_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .alert_output_o(alert_output_o),
  .shutdown_o(shutdown_o), .conv_start_o(conv_start_o));

/* File: sim/tas_core_test.sv */
// self-checking bench for the thermal alarm core
`timescale 1ns/1ps
module tas_core_test;
  localparam int CONV = 50; // shortened conversion period
  logic clock_i = 1'b0;
  logic link_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [2:0] pins = 3'h6; // address select levels, high pin first
  logic [8:0] temp = 9'h095; // converter result
  logic scl, pull, sda_o, sda_oe_o, alert, shdn, conv;
  wire sda = !(pull || sda_oe_o); // pulled-up open-drain data line
  int bad_count = 0;
  int samples_checked = 0;
  always #5 clock_i = !clock_i;
  initial #7 forever #15 link_clk_i = !link_clk_i;
  tas_core #(.CONV_CYCLES(CONV)) dut (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .link_clk_i(link_clk_i), .scl_i(scl), .sda_i(sda),
    .addr_select_high_i(pins[2]), .addr_select_mid_i(pins[1]), .addr_select_low_i(pins[0]),
    .temp_code_i(temp), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .alert_output_o(alert),
    .shutdown_o(shdn), .conv_start_o(conv));
  tas_host_model host (.sda_i(sda), .scl_o(scl), .pull_o(pull));
  // compare and count
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // verdict and end of run
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // write: pointer byte, then n bytes from the top of w
  task automatic wr(input logic [1:0] ptr, input int n, input logic [15:0] w);
    logic ack;
    logic [8:0] q;
    host.bus_start();
    host.address(pins, 1'b0, ack);
    check("write address ack", 16'h1, {15'h0, ack});
    host.frame({6'h00, ptr, 1'b1}, q);
    check("pointer ack", 16'h0, {15'h0, q[0]});
    for (int i = 0; i < n; i++) begin
      host.frame({w[15-8*i -: 8], 1'b1}, q);
      check("data ack", 16'h0, {15'h0, q[0]});
    end
    host.bus_stop();
  endtask
  // read one word from register ptr
  task automatic rd(input logic [1:0] ptr, output logic [15:0] w);
    logic ack;
    logic [8:0] q;
    wr(ptr, 0, 16'h0000);
    host.bus_start();
    host.address(pins, 1'b1, ack);
    check("read address ack", 16'h1, {15'h0, ack});
    host.frame(9'h1fe, q);
    w[15:8] = q[8:1];
    host.frame(9'h1ff, q);
    w[7:0] = q[8:1];
    host.bus_stop();
  endtask
  // new converter result, set between conversions
  // changed right after a conversion, or at once in shutdown, so the next one sees it settled
  task automatic heat(input logic [8:0] t);
    @(posedge clock_i iff (conv || shdn)) temp <= t;
  endtask
  // wait n conversions plus the alert pipeline
  task automatic cw(input int n);
    repeat (n) @(posedge clock_i iff conv);
    repeat (6) @(posedge clock_i);
  endtask
  // compare the alert pin level
  task automatic ca(input logic e);
    @(negedge clock_i);
    check("alert pin", {15'h0, e}, {15'h0, alert});
  endtask
  // main sequence
  initial begin
    logic [15:0] w;
    logic ack;
    logic [8:0] q;
    int n;
    int k;
    repeat (8) @(posedge clock_i);
    reset_n_i <= 1'b1;
    ca(1'b1);
    check("shutdown after reset", 16'h0, {15'h0, shdn});
    repeat (20) @(posedge clock_i);
    rd(tas_pkg::PTR_SET, w);
    check("setpoint default", 16'h5000, w);
    rd(tas_pkg::PTR_HYST, w);
    check("hysteresis default", 16'h4b00, w);
    rd(tas_pkg::PTR_CFG, w);
    check("config default", 16'h0000, w);
    // foreign prefix, then pins in reversed order
    host.bus_start();
    host.frame({4'h8, pins, 1'b0, 1'b1}, q);
    check("foreign prefix ack", 16'h1, {15'h0, q[0]});
    host.bus_start();
    host.address(3'h3, 1'b0, ack);
    check("foreign pins ack", 16'h0, {15'h0, ack});
    host.bus_stop();
    // comparator thresholds at their boundaries
    heat(9'h0a1);
    cw(2);
    ca(1'b0);
    heat(9'h096);
    cw(2);
    ca(1'b0);
    heat(9'h095);
    cw(2);
    ca(1'b1);
    // every fault queue code
    for (int f = 0; f < 4; f++) begin
      n = (f == 3) ? 6 : (1 << f);
      wr(tas_pkg::PTR_CFG, 1, {3'h0, f[1:0], 3'h0, 8'h00});
      heat(9'h0a1);
      cw(n - 1);
      ca(1'b1);
      cw(1);
      ca(1'b0);
      heat(9'h095);
      cw(n);
      ca(1'b1);
    end
    // a middle result breaks the run of hot results
    heat(9'h0a1);
    cw(3);
    heat(9'h098);
    cw(1);
    heat(9'h0a1);
    cw(5);
    ca(1'b1);
    cw(1);
    ca(1'b0);
    heat(9'h095);
    cw(6);
    // active-high polarity
    wr(tas_pkg::PTR_CFG, 1, 16'h0400);
    ca(1'b0);
    heat(9'h0a1);
    cw(1);
    ca(1'b1);
    heat(9'h095);
    cw(1);
    // interrupt mode
    wr(tas_pkg::PTR_CFG, 1, 16'h0200);
    heat(9'h0a1);
    cw(1);
    ca(1'b0);
    heat(9'h095);
    cw(2);
    ca(1'b0);
    heat(9'h098);
    cw(1);
    rd(tas_pkg::PTR_TEMP, w);
    check("temperature word", {9'h098, 7'h00}, w);
    ca(1'b1);
    heat(9'h095);
    cw(1);
    ca(1'b0);
    rd(tas_pkg::PTR_TEMP, w);
    ca(1'b1);
    heat(9'h0a1);
    cw(1);
    ca(1'b0);
    wr(tas_pkg::PTR_CFG, 1, 16'h0300);
    ca(1'b1);
    check("shutdown flag", 16'h1, {15'h0, shdn});
    k = 0;
    repeat (200) @(posedge clock_i) k += conv;
    check("conversions in shutdown", 16'h0, 16'(k));
    wr(tas_pkg::PTR_HYST, 2, 16'h4a80);
    rd(tas_pkg::PTR_HYST, w);
    check("hysteresis in shutdown", 16'h4a80, w);
    // comparator state held through shutdown
    wr(tas_pkg::PTR_CFG, 1, 16'h0000);
    cw(1);
    ca(1'b0);
    wr(tas_pkg::PTR_CFG, 1, 16'h0100);
    heat(9'h090);
    repeat (300) @(posedge clock_i);
    ca(1'b0);
    wr(tas_pkg::PTR_CFG, 1, 16'h0000);
    cw(1);
    ca(1'b1);
    // new select pin levels: old address refused, new one answered
    @(posedge clock_i) pins <= 3'h1;
    repeat (10) @(posedge clock_i);
    host.bus_start();
    host.address(3'h6, 1'b0, ack);
    check("old pins ack", 16'h0, {15'h0, ack});
    host.bus_stop();
    rd(tas_pkg::PTR_HYST, w);
    check("hysteresis with new pins", 16'h4a80, w);
    complete_run();
  end
  // watchdog against a hung run
  initial begin
    #1000000;
    bad_count++;
    complete_run();
  end
endmodule
